// [logic/sioc_defs.svh]
// Offsets-free constants for the serial and I/O line configuration block
`ifndef SIOC_DEFS_SVH
`define SIOC_DEFS_SVH

`define SIOC_BITS_PER_CHAR 32'd10
`define SIOC_RATE_MIN_NS   17'h00080
`define SIOC_RATE_MAX_NS   17'h1c200
`define SIOC_STD_CODE_MAX  17'h00007

// Reset values of every setting, plus the framed-mode maximum
`define SIOC_RATE_RST      17'h00003
`define SIOC_GAP_RST       8'h03
`define SIOC_FRAMED_RST    2'h0
`define SIOC_FRAMED_MAX    2'h2
`define SIOC_PULLUP_RST    8'hff
`define SIOC_L8_RST        3'h0
`define SIOC_L7_RST        3'h1
`define SIOC_L6_RST        3'h0
`define SIOC_L5_RST        3'h1
`define SIOC_LOW_RST       3'h0
`define SIOC_FWD_RST       1'h1
`define SIOC_SAMPLES_RST   8'h01

// Function codes
`define SIOC_FN_OFF        3'h0
`define SIOC_FN_SPECIAL    3'h1
`define SIOC_FN_ANALOG     3'h2
`define SIOC_FN_DIN        3'h3
`define SIOC_FN_DRIVE_LO   3'h4
`define SIOC_FN_DRIVE_HI   3'h5

// Pull-up map field positions
`define SIOC_PU_LINE4      0
`define SIOC_PU_LINE3      1
`define SIOC_PU_LINE0      4
`define SIOC_PU_LINE6      5
`define SIOC_PU_SLEEP      6
`define SIOC_PU_SERIAL_IN  7

`endif

// [logic/sioc_pkg.sv]
// Types shared by the serial and I/O line configuration block
package sioc_pkg;

   // Setting selected by a command-mode access
   typedef enum logic [3:0] {
      SIOC_SEL_RATE    = 4'h0,
      SIOC_SEL_GAP     = 4'h1,
      SIOC_SEL_FRAMED  = 4'h2,
      SIOC_SEL_PULLUP  = 4'h3,
      SIOC_SEL_L8      = 4'h4,
      SIOC_SEL_L7      = 4'h5,
      SIOC_SEL_L6      = 4'h6,
      SIOC_SEL_L5      = 4'h7,
      SIOC_SEL_L0      = 4'h8,
      SIOC_SEL_L1      = 4'h9,
      SIOC_SEL_L2      = 4'ha,
      SIOC_SEL_L3      = 4'hb,
      SIOC_SEL_L4      = 4'hc,
      SIOC_SEL_FWD     = 4'hd,
      SIOC_SEL_SAMPLES = 4'he
   } sioc_sel_e;

   // Packetizer states, one-hot
   typedef enum logic [1:0] {
      SIOC_ST_COLLECT = 2'b01,
      SIOC_ST_DRAIN   = 2'b10
   } sioc_state_e;

   // Command-mode parameter access
   typedef struct packed {
      logic        wr;
      logic        rd;
      sioc_sel_e   sel;
      logic [16:0] wdata;
   } sioc_cfg_req_s;

   // Decoded line configuration
   typedef struct packed {
      logic [2:0]      line8_function;
      logic [2:0]      line7_function;
      logic [2:0]      line6_function;
      logic [2:0]      line5_function;
      logic [4:0][2:0] low_lines_function;
      logic            cts_flow_en;
      logic            rts_flow_en;
      logic            assoc_ind_en;
   } sioc_line_cfg_s;

endpackage

// [logic/sioc_top.sv]
// Serial interface and I/O line configuration with packetizing buffer
`timescale 1ns/10ps
`default_nettype none
`include "sioc_defs.svh"

// Small synchronous FIFO between serial receiver and radio side
module sioc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic                       ref_clk,
   input  wire logic                       rst_n,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [WIDTH-1:0]           in_data,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic      [WIDTH-1:0]           out_data,
   output logic      [$clog2(DEPTH+1)-1:0] level
);
   localparam int AW = $clog2(DEPTH);
   localparam int LW = $clog2(DEPTH + 1);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("sioc_fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [LW-1:0]    level_ff;
   logic             push;
   logic             pop;

   // Honest full and empty from the level count
   assign in_ready  = (level_ff != LW'(DEPTH));
   assign out_valid = (level_ff != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_ff[rd_ptr_ff];
   assign level     = level_ff;

   // Storage has no reset; only pointers and level need a defined value
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   // Pointers and level
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         level_ff  <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + AW'(1);
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + AW'(1);
         end
         if (push && !pop) begin
            level_ff <= level_ff + LW'(1);
         end else if (pop && !push) begin
            level_ff <= level_ff - LW'(1);
         end
      end
   end
endmodule

module sioc_top
   import sioc_pkg::*;
#(
   parameter int CLK_HZ     = 125000000,
   parameter int FIFO_DEPTH = 4
) (
   input  wire logic           ref_clk,
   input  wire logic           rst_n,
   // Command-mode parameter access
   input  wire sioc_cfg_req_s  cfg_req,
   output logic                cfg_ack,
   output logic                cfg_err,
   output logic [16:0]         cfg_rdata,
   // Received serial characters
   input  wire logic           ser_valid,
   output logic                ser_ready,
   input  wire logic [7:0]     ser_data,
   // Characters toward the radio
   output logic                radio_valid,
   input  wire logic           radio_ready,
   output logic [7:0]          radio_data,
   output logic                radio_last,
   // Samples and received I/O data
   input  wire logic           sample_taken,
   output logic                samples_send,
   input  wire logic           rx_io_valid,
   output logic                io_fwd_pkt,
   output logic                io_fwd_framed,
   // Settings seen by the rest of the modem
   output logic [19:0]         baud_divisor,
   output logic [1:0]          framed_mode,
   output logic [7:0]          pullup_enable_map,
   output sioc_line_cfg_s      line_cfg
);
   localparam int LW = $clog2(FIFO_DEPTH + 1);

   if (CLK_HZ < 4 * 115200) begin : g_bad_clk
      $error("sioc_top clock too slow for the fastest serial rate");
   end

   logic [16:0]     rate_ff;
   logic [19:0]     div_ff;
   logic [23:0]     chartime_ff;
   logic [7:0]      gap_ff;
   logic [1:0]      framed_ff;
   logic [7:0]      pullup_ff;
   logic [2:0]      l8_ff;
   logic [2:0]      l7_ff;
   logic [2:0]      l6_ff;
   logic [2:0]      l5_ff;
   logic [2:0]      low_ff [5];
   logic            fwd_ff;
   logic [7:0]      samples_ff;
   logic            ok;
   logic [2:0]      wfn;
   logic [16:0]     req_rate;
   logic [19:0]     new_div;
   logic [16:0]     achieved;
   logic [LW-1:0]   level;
   logic            fifo_valid;
   logic            ser_push;
   sioc_state_e     state_ff;
   sioc_state_e     nxt_state;
   logic [23:0]     cyc_ff;
   logic [7:0]      idle_ff;
   logic            gap_met;
   logic [7:0]      samp_cnt_ff;

   // Standard code to rate in bits per second
   function automatic logic [16:0] std_rate(input logic [2:0] code);
      logic [16:0] r;
      r = 17'h004b0;
      case (code)
         3'h0:    r = 17'h004b0;
         3'h1:    r = 17'h00960;
         3'h2:    r = 17'h012c0;
         3'h3:    r = 17'h02580;
         3'h4:    r = 17'h04b00;
         3'h5:    r = 17'h09600;
         3'h6:    r = 17'h0e100;
         default: r = 17'h1c200;
      endcase
      return r;
   endfunction

   // Range and code check of a write; codes differ per line
   assign wfn = cfg_req.wdata[2:0];
   always_comb begin
      ok = 1'b0;
      case (cfg_req.sel)
         SIOC_SEL_RATE: ok = (cfg_req.wdata <= `SIOC_STD_CODE_MAX) ||
            ((cfg_req.wdata >= `SIOC_RATE_MIN_NS) &&
             (cfg_req.wdata <= `SIOC_RATE_MAX_NS));
         SIOC_SEL_GAP:     ok = (cfg_req.wdata[16:8] == '0);
         SIOC_SEL_FRAMED:  ok = (cfg_req.wdata[16:2] == '0) &&
                                (cfg_req.wdata[1:0] <= `SIOC_FRAMED_MAX);
         SIOC_SEL_PULLUP:  ok = (cfg_req.wdata[16:8] == '0);
         SIOC_SEL_L8: ok = (cfg_req.wdata[16:3] == '0) &&
            (wfn == `SIOC_FN_OFF || wfn == `SIOC_FN_DIN);
         SIOC_SEL_L7, SIOC_SEL_L6: ok = (cfg_req.wdata[16:3] == '0) &&
            (wfn <= `SIOC_FN_DRIVE_HI) && (wfn != `SIOC_FN_ANALOG);
         SIOC_SEL_L5: ok = (cfg_req.wdata[16:3] == '0) &&
            (wfn <= `SIOC_FN_DRIVE_HI);
         SIOC_SEL_L0, SIOC_SEL_L1, SIOC_SEL_L2, SIOC_SEL_L3, SIOC_SEL_L4:
            ok = (cfg_req.wdata[16:3] == '0) &&
                 (wfn <= `SIOC_FN_DRIVE_HI) &&
                 (wfn != `SIOC_FN_SPECIAL);
         SIOC_SEL_FWD:     ok = (cfg_req.wdata[16:1] == '0);
         SIOC_SEL_SAMPLES: ok = (cfg_req.wdata[16:8] == '0) &&
                                (cfg_req.wdata[7:0] != 8'h00);
         default:          ok = 1'b0;
      endcase
   end

   // Divisor rounded to nearest; custom rates land on what it gives
   assign req_rate = (cfg_req.wdata <= `SIOC_STD_CODE_MAX) ?
                     std_rate(cfg_req.wdata[2:0]) : cfg_req.wdata;
   assign new_div  = 20'((CLK_HZ + (32'(req_rate) >> 1)) / 32'(req_rate));
   assign achieved = 17'(CLK_HZ / 32'(div_ff));

   // Settings; a refused write leaves the old value in place
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rate_ff     <= `SIOC_RATE_RST;
         div_ff      <= 20'((CLK_HZ + 4800) / 9600);
         chartime_ff <= 24'((CLK_HZ + 4800) / 9600 * `SIOC_BITS_PER_CHAR);
         gap_ff      <= `SIOC_GAP_RST;
         framed_ff   <= `SIOC_FRAMED_RST;
         pullup_ff   <= `SIOC_PULLUP_RST;
         l8_ff       <= `SIOC_L8_RST;
         l7_ff       <= `SIOC_L7_RST;
         l6_ff       <= `SIOC_L6_RST;
         l5_ff       <= `SIOC_L5_RST;
         low_ff      <= '{default: `SIOC_LOW_RST};
         fwd_ff      <= `SIOC_FWD_RST;
         samples_ff  <= `SIOC_SAMPLES_RST;
      end else if (cfg_req.wr && ok) begin
         case (cfg_req.sel)
            SIOC_SEL_RATE: begin
               rate_ff     <= cfg_req.wdata;
               div_ff      <= new_div;
               chartime_ff <= 24'(new_div) * 24'(`SIOC_BITS_PER_CHAR);
            end
            SIOC_SEL_GAP:     gap_ff     <= cfg_req.wdata[7:0];
            SIOC_SEL_FRAMED:  framed_ff  <= cfg_req.wdata[1:0];
            SIOC_SEL_PULLUP:  pullup_ff  <= cfg_req.wdata[7:0];
            SIOC_SEL_L8:      l8_ff      <= wfn;
            SIOC_SEL_L7:      l7_ff      <= wfn;
            SIOC_SEL_L6:      l6_ff      <= wfn;
            SIOC_SEL_L5:      l5_ff      <= wfn;
            SIOC_SEL_FWD:     fwd_ff     <= cfg_req.wdata[0];
            SIOC_SEL_SAMPLES: samples_ff <= cfg_req.wdata[7:0];
            default: begin
               if (cfg_req.sel >= SIOC_SEL_L0 && cfg_req.sel <= SIOC_SEL_L4)
                  low_ff[3'(cfg_req.sel - SIOC_SEL_L0)] <= wfn;
            end
         endcase
      end
   end

   // Answer one cycle after any access; reads show live settings
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ack   <= 1'b0;
         cfg_err   <= 1'b0;
         cfg_rdata <= '0;
      end else begin
         cfg_ack <= cfg_req.wr | cfg_req.rd;
         cfg_err <= cfg_req.wr & ~ok;
         if (cfg_req.rd) begin
            case (cfg_req.sel)
               SIOC_SEL_RATE: cfg_rdata <= (rate_ff <= `SIOC_STD_CODE_MAX)
                                           ? rate_ff : achieved;
               SIOC_SEL_GAP:     cfg_rdata <= 17'(gap_ff);
               SIOC_SEL_FRAMED:  cfg_rdata <= 17'(framed_ff);
               SIOC_SEL_PULLUP:  cfg_rdata <= 17'(pullup_ff);
               SIOC_SEL_L8:      cfg_rdata <= 17'(l8_ff);
               SIOC_SEL_L7:      cfg_rdata <= 17'(l7_ff);
               SIOC_SEL_L6:      cfg_rdata <= 17'(l6_ff);
               SIOC_SEL_L5:      cfg_rdata <= 17'(l5_ff);
               SIOC_SEL_FWD:     cfg_rdata <= 17'(fwd_ff);
               SIOC_SEL_SAMPLES: cfg_rdata <= 17'(samples_ff);
               default: begin
                  if (cfg_req.sel >= SIOC_SEL_L0 &&
                      cfg_req.sel <= SIOC_SEL_L4)
                     cfg_rdata <= 17'(low_ff[3'(cfg_req.sel - SIOC_SEL_L0)]);
                  else
                     cfg_rdata <= '0;
               end
            endcase
         end
      end
   end

   // Settings presented to the modem
   assign baud_divisor      = div_ff;
   assign framed_mode       = framed_ff;
   assign pullup_enable_map = pullup_ff;
   assign io_fwd_framed     = fwd_ff;
   assign line_cfg.line8_function = l8_ff;
   assign line_cfg.line7_function = l7_ff;
   assign line_cfg.line6_function = l6_ff;
   assign line_cfg.line5_function = l5_ff;
   assign line_cfg.cts_flow_en    = (l7_ff == `SIOC_FN_SPECIAL);
   assign line_cfg.rts_flow_en    = (l6_ff == `SIOC_FN_SPECIAL);
   assign line_cfg.assoc_ind_en   = (l5_ff == `SIOC_FN_SPECIAL);
   for (genvar i = 0; i < 5; i++) begin : g_low
      assign line_cfg.low_lines_function[i] = low_ff[i];
   end

   // Character buffer; a stalled radio backs up into the receiver
   sioc_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .in_valid  (ser_valid),
      .in_ready  (ser_ready),
      .in_data   (ser_data),
      .out_valid (fifo_valid),
      .out_ready (radio_ready && state_ff == SIOC_ST_DRAIN),
      .out_data  (radio_data),
      .level     (level)
   );
   assign ser_push = ser_valid & ser_ready;

   // Idle time measured in whole character times since last arrival
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cyc_ff  <= '0;
         idle_ff <= '0;
      end else if (ser_push) begin
         cyc_ff  <= '0;
         idle_ff <= '0;
      end else if (cyc_ff + 24'h1 >= chartime_ff) begin
         cyc_ff  <= '0;
         if (idle_ff != 8'hff)
            idle_ff <= idle_ff + 8'h1;
      end else begin
         cyc_ff <= cyc_ff + 24'h1;
      end
   end

   // Zero gap means no waiting at all
   assign gap_met = (gap_ff == 8'h00) || (idle_ff >= gap_ff);

   // Collect until the line goes quiet, then drain the buffer
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SIOC_ST_COLLECT:
            if (gap_met && fifo_valid) nxt_state = SIOC_ST_DRAIN;
         SIOC_ST_DRAIN:
            if (radio_ready && level == LW'(1) && !ser_push)
               nxt_state = SIOC_ST_COLLECT;
         default: nxt_state = SIOC_ST_COLLECT;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         state_ff <= SIOC_ST_COLLECT;
      else
         state_ff <= nxt_state;
   end

   // Packet ends at the last buffered byte, or each byte if no gap
   assign radio_valid = fifo_valid && state_ff == SIOC_ST_DRAIN;
   assign radio_last  = radio_valid && ((gap_ff == 8'h00) ||
                        (level == LW'(1) && !ser_push));

   // Sample counting and forwarding of received I/O data
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         samp_cnt_ff  <= '0;
         samples_send <= 1'b0;
         io_fwd_pkt   <= 1'b0;
      end else begin
         io_fwd_pkt   <= rx_io_valid & fwd_ff;
         samples_send <= 1'b0;
         if (sample_taken) begin
            if (samp_cnt_ff + 8'h1 >= samples_ff) begin
               samp_cnt_ff  <= '0;
               samples_send <= 1'b1;
            end else begin
               samp_cnt_ff <= samp_cnt_ff + 8'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// [tb/sioc_top_monitor.sv]
// Port checker for the serial and I/O line configuration block
`timescale 1ns/10ps
`default_nettype none
module sioc_top_monitor
   import sioc_pkg::*;
(
   input wire logic           ref_clk,
   input wire logic           rst_n,
   input wire sioc_cfg_req_s  cfg_req,
   input wire logic           cfg_ack,
   input wire logic           cfg_err,
   input wire logic           radio_valid,
   input wire logic           radio_ready,
   input wire logic [7:0]     radio_data,
   input wire logic           radio_last,
   input wire logic           sample_taken,
   input wire logic           samples_send,
   input wire logic           rx_io_valid,
   input wire logic           io_fwd_pkt,
   input wire logic           io_fwd_framed,
   input wire logic [1:0]     framed_mode,
   input wire logic [7:0]     pullup_enable_map,
   input wire sioc_line_cfg_s line_cfg
);
   // One clock domain
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   property p_ack;
      (cfg_req.wr || cfg_req.rd) |=> cfg_ack;
   endproperty
   a_ack: assert property (p_ack)
      else $error("access not acknowledged");
   property p_ack_cause;
      cfg_ack |-> $past(cfg_req.wr) || $past(cfg_req.rd);
   endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("acknowledge without access");
   property p_err;
      cfg_err |-> cfg_ack;
   endproperty
   a_err: assert property (p_err)
      else $error("refusal outside acknowledge");
   property p_pullup;
      cfg_req.wr && cfg_req.sel == SIOC_SEL_PULLUP && !cfg_req.wdata[16:8]
      |=> !cfg_err && pullup_enable_map == $past(cfg_req.wdata[7:0]);
   endproperty
   a_pullup: assert property (p_pullup)
      else $error("pull-up map write lost");
   property p_framed;
      framed_mode != 2'h3;
   endproperty
   a_framed: assert property (p_framed)
      else $error("framed mode out of range");
   property p_l8;
      line_cfg.line8_function == 3'h0 || line_cfg.line8_function == 3'h3;
   endproperty
   a_l8: assert property (p_l8)
      else $error("line 8 function unavailable");
   property p_codes;
      line_cfg.line7_function != 3'h2 && line_cfg.line6_function != 3'h2 &&
      line_cfg.low_lines_function[0] != 3'h1 &&
      line_cfg.low_lines_function[4] != 3'h1;
   endproperty
   a_codes: assert property (p_codes)
      else $error("unavailable code held");
   property p_flow;
      line_cfg.cts_flow_en == (line_cfg.line7_function == 3'h1) &&
      line_cfg.rts_flow_en == (line_cfg.line6_function == 3'h1) &&
      line_cfg.assoc_ind_en == (line_cfg.line5_function == 3'h1);
   endproperty
   a_flow: assert property (p_flow)
      else $error("special line function mismatch");
   property p_fwd;
      io_fwd_pkt == ($past(rx_io_valid) && $past(io_fwd_framed));
   endproperty
   a_fwd: assert property (p_fwd)
      else $error("forwarded packet mismatch");
   property p_hold;
      radio_valid && !radio_ready |=> radio_valid && $stable(radio_data);
   endproperty
   a_hold: assert property (p_hold)
      else $error("radio data lost while stalled");
   property p_samp;
      samples_send |-> $past(sample_taken) || $past(sample_taken, 2);
   endproperty
   a_samp: assert property (p_samp)
      else $error("sample send without sample");
   c_err: cover property (cfg_err);
   c_last: cover property (radio_valid && radio_ready && radio_last);
   c_samp: cover property (samples_send);
endmodule
`default_nettype wire

// [tb/sioc_host_model.sv]
// Host-side serial character source with adjustable pacing
`timescale 1ns/10ps
`default_nettype none
module sioc_host_model (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       ser_ready,
   output var  logic       ser_valid,
   output var  logic [7:0] ser_data
);
   logic [7:0] q[$];
   int         pace = 0;
   int         wait_n = 0;

   task automatic push(input logic [7:0] b);
      q.push_back(b);
   endtask

   // Hold until taken; idle data toggles to expose stale samples
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ser_valid <= 1'b0;
         ser_data  <= 8'h5a;
      end else if (ser_valid && ser_ready) begin
         ser_valid <= 1'b0;
         ser_data  <= ~ser_data;
         wait_n    <= pace;
      end else if (!ser_valid && wait_n > 0) begin
         wait_n   <= wait_n - 1;
         ser_data <= ~ser_data;
      end else if (!ser_valid && q.size() > 0) begin
         ser_valid <= 1'b1;
         ser_data  <= q.pop_front();
      end else if (!ser_valid) begin
         ser_data <= ~ser_data;
      end
   end
endmodule
`default_nettype wire

// [tb/serial_and_io_line_config_test.sv]
// Self-checking bench for the serial and I/O line configuration block
`timescale 1ns/10ps
`default_nettype none
module serial_and_io_line_config_test;
   import sioc_pkg::*;
   localparam int CLK_HZ = 125000000;
   logic           ref_clk = 1'b0;
   logic           rst_n = 1'b0;
   sioc_cfg_req_s  cfg_req = '0;
   logic           cfg_ack, cfg_err, ser_valid, ser_ready;
   logic           radio_valid, radio_last, samples_send;
   logic           radio_ready = 1'b0, sample_taken = 1'b0;
   logic           rx_io_valid = 1'b0, io_fwd_pkt, io_fwd_framed;
   logic [16:0]    cfg_rdata;
   logic [7:0]     ser_data, radio_data, pullup_enable_map;
   logic [19:0]    baud_divisor;
   logic [1:0]     framed_mode;
   sioc_line_cfg_s line_cfg;
   logic [16:0]    shadow [15] = '{17'h3, 17'h3, 17'h0, 17'hff, 17'h0,
      17'h1, 17'h0, 17'h1, 17'h0, 17'h0, 17'h0, 17'h0, 17'h0, 17'h1, 17'h1};
   logic [16:0]    vals [9] = '{17'h0, 17'h1, 17'h2, 17'h3, 17'h4, 17'h5,
      17'h6, 17'hff, 17'h100};
   logic [16:0]    bad [3] = '{17'h8, 17'h7f, 17'h1c201};
   int             rates [8] = '{1200, 2400, 4800, 9600, 19200, 38400,
      57600, 115200};
   logic [15:0]    lfsr = 16'hab14;
   int             n_mismatch = 0;
   int             checks_done = 0;

   always #4 ref_clk = ~ref_clk;

   sioc_top #(.CLK_HZ(CLK_HZ)) dut (.ref_clk(ref_clk),
      .rst_n(rst_n), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
      .cfg_err(cfg_err), .cfg_rdata(cfg_rdata), .ser_valid(ser_valid),
      .ser_ready(ser_ready), .ser_data(ser_data),
      .radio_valid(radio_valid), .radio_ready(radio_ready),
      .radio_data(radio_data), .radio_last(radio_last),
      .sample_taken(sample_taken), .samples_send(samples_send),
      .rx_io_valid(rx_io_valid), .io_fwd_pkt(io_fwd_pkt),
      .io_fwd_framed(io_fwd_framed), .baud_divisor(baud_divisor),
      .framed_mode(framed_mode), .pullup_enable_map(pullup_enable_map),
      .line_cfg(line_cfg));
   sioc_host_model u_host (.ref_clk(ref_clk), .rst_n(rst_n),
      .ser_ready(ser_ready), .ser_valid(ser_valid), .ser_data(ser_data));

   function automatic logic [15:0] step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Divisor rounded to nearest
   function automatic logic [19:0] div_of(input int rate);
      return 20'((CLK_HZ + rate / 2) / rate);
   endfunction

   function automatic logic legal(input int s, input logic [16:0] v);
      case (s)
         1, 3: return v <= 17'hff;
         2: return v <= 17'h2;
         4: return v == 17'h0 || v == 17'h3;
         5, 6: return v <= 17'h5 && v != 17'h2;
         7: return v <= 17'h5;
         13: return v <= 17'h1;
         14: return v >= 17'h1 && v <= 17'hff;
         default: return v <= 17'h5 && v != 17'h1;
      endcase
   endfunction

   // Level of a setting at the outputs, else the readback
   function automatic logic [16:0] seen(input int s);
      case (s)
         2: return 17'(framed_mode);
         3: return 17'(pullup_enable_map);
         4: return 17'(line_cfg.line8_function);
         5: return 17'(line_cfg.line7_function);
         6: return 17'(line_cfg.line6_function);
         7: return 17'(line_cfg.line5_function);
         8, 9, 10, 11, 12: return 17'(line_cfg.low_lines_function[s - 8]);
         13: return 17'(io_fwd_framed);
         default: return cfg_rdata;
      endcase
   endfunction

   task automatic chk(input string what, input logic [19:0] exp,
                      input logic [19:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic print_verdict;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // One access; answer checked while it stands
   task automatic cfg(input logic w, input int s, input logic [16:0] d);
      @(posedge ref_clk);
      cfg_req <= '{wr: w, rd: !w, sel: sioc_sel_e'(s), wdata: d};
      @(posedge ref_clk);
      cfg_req <= '0;
      #1;
      chk("ack", 20'h1, 20'(cfg_ack));
   endtask

   task automatic pulse(input logic smp, output int n);
      @(posedge ref_clk);
      if (smp)
         sample_taken <= 1'b1;
      else
         rx_io_valid <= 1'b1;
      n = 0;
      @(posedge ref_clk);
      sample_taken <= 1'b0;
      rx_io_valid <= 1'b0;
      repeat (3) begin
         #1;
         n += smp ? int'(samples_send) : int'(io_fwd_pkt);
         @(posedge ref_clk);
      end
   endtask

   // Take one character, stalling at random
   task automatic rx(input logic [7:0] d, input logic l, input logic stall);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 15000 && !hit; i++) begin
         @(negedge ref_clk);
         hit = radio_valid && radio_ready;
         if (hit) begin
            chk("radio data", 20'(d), 20'(radio_data));
            chk("radio last", 20'(l), 20'(radio_last));
         end
         @(posedge ref_clk);
         lfsr = step(lfsr);
         radio_ready <= !stall || lfsr[0];
      end
      if (!hit) begin
         chk("radio timeout", 20'h1, 20'h0);
         print_verdict;
      end
   endtask

   initial begin
      int v, n, s, k;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      chk("divisor", 20'h32dd, baud_divisor);
      for (s = 0; s < 15; s++) begin
         cfg(1'b0, s, 17'h0);
         chk("default", 20'(shadow[s]), 20'(cfg_rdata));
         chk("level", 20'(shadow[s]), 20'(seen(s)));
      end
      for (k = 0; k < 8; k++) begin
         cfg(1'b1, 0, 17'(k));
         cfg(1'b0, 0, 17'h0);
         chk("rate code", 20'(k), 20'(cfg_rdata));
         chk("divisor", div_of(rates[k]), baud_divisor);
      end
      for (k = 0; k < 3; k++) begin
         cfg(1'b1, 0, bad[k]);
         chk("rate refused", 20'h1, 20'(cfg_err));
      end
      cfg(1'b1, 0, 17'h1c200);
      cfg(1'b0, 0, 17'h0);
      chk("achieved", 20'(CLK_HZ / int'(div_of(115200))), 20'(cfg_rdata));
      // Every setting but the rate: legal, unavailable, random values
      for (s = 1; s < 15; s++) begin
         for (k = 0; k < 10; k++) begin
            lfsr = step(lfsr);
            v = (k == 9) ? int'(lfsr[8:0]) : int'(vals[k]);
            cfg(1'b1, s, 17'(v));
            chk("refused", 20'(!legal(s, 17'(v))), 20'(cfg_err));
            if (legal(s, 17'(v)))
               shadow[s] = 17'(v);
            cfg(1'b0, s, 17'h0);
            chk("readback", 20'(shadow[s]), 20'(cfg_rdata));
            chk("level", 20'(shadow[s]), 20'(seen(s)));
         end
      end
      cfg(1'b1, 14, 17'h3);
      for (k = 0; k < 3; k++) begin
         pulse(1'b1, n);
         chk("samples send", 20'(k == 2), 20'(n));
      end
      cfg(1'b1, 2, 17'h0);
      cfg(1'b1, 13, 17'h1);
      pulse(1'b0, n);
      chk("forward", 20'h1, 20'(n));
      chk("forward framed", 20'h1, 20'(io_fwd_framed));
      cfg(1'b1, 13, 17'h0);
      pulse(1'b0, n);
      chk("forward off", 20'h0, 20'(n));
      // One character time of gap: fill, hold, then drain
      cfg(1'b1, 1, 17'h1);
      for (k = 0; k < 4; k++)
         u_host.push(8'(8'h41 + k));
      for (k = 0; k < 40 && ser_ready !== 1'b0; k++)
         @(negedge ref_clk);
      chk("buffer full", 20'h0, 20'(ser_ready));
      n = 0;
      repeat (5000) begin
         @(negedge ref_clk);
         n += int'(radio_valid);
      end
      chk("early send", 20'h0, 20'(n));
      for (k = 0; k < 4; k++)
         rx(8'(8'h41 + k), k == 3, 1'b1);
      // Zero gap: one character per packet
      cfg(1'b1, 1, 17'h0);
      u_host.pace = 40;
      u_host.push(8'h78);
      u_host.push(8'h79);
      rx(8'h78, 1'b1, 1'b0);
      rx(8'h79, 1'b1, 1'b0);
      print_verdict;
   end
endmodule

bind sioc_top sioc_top_monitor u_mon (.ref_clk(ref_clk), .rst_n(rst_n),
   .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_err(cfg_err),
   .radio_valid(radio_valid), .radio_ready(radio_ready),
   .radio_data(radio_data), .radio_last(radio_last),
   .sample_taken(sample_taken), .samples_send(samples_send),
   .rx_io_valid(rx_io_valid), .io_fwd_pkt(io_fwd_pkt),
   .io_fwd_framed(io_fwd_framed), .framed_mode(framed_mode),
   .pullup_enable_map(pullup_enable_map), .line_cfg(line_cfg));
`default_nettype wire
